// [shared/ptb_pkg.sv]
// How it works
// RULE_01: With the run bit clear the divider is held at zero, and it counts from zero once set.
// RULE_02: The rollover flag is set each time the divider overflows at the selected tap.
// RULE_03: A newly set flag raises an interrupt request when the interrupt enable bit is one.
// RULE_04: The acknowledge bit reads as zero, a one written to it clears the flag, a zero does nothing.
// RULE_05: The first flag after enabling comes at half the period, every later one at the full period.
// RULE_06: The source clock is the external clock while external clock on is set, else the internal one.
// RULE_07: Bank zero taps for codes 000 to 111 divide by 32768, 8192, 2048, 128, 64, 32, 16 and 8.
// RULE_08: Bank one taps for codes 000 to 111 divide by 4194304 down to 1024 as tabled.
// RULE_09: Software changes the tap select only while the timebase is stopped.
// RULE_10: In stop mode the timebase runs only if the oscillator is kept running in stop.
// RULE_11: The timebase keeps running in wait mode, and its register is not reachable in wait or stop.
// RULE_12: Clearing the run bit leaves the flag alone, only an acknowledge clears it.
// RULE_13: Reset clears both the interrupt enable bit and the run bit.
// RULE_14: The chain has fifteen stages with eight taps, behind a fixed divide-by-128 prescaler in bank one only.
// RULE_15: The interrupt output stays high as long as flag and enable are both set.
// RULE_16: A rollover in the same cycle as an acknowledge leaves the flag set.
package ptb_pkg;
    localparam int unsigned ADDR_W   = 12;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STAT = 12'h004;
    localparam logic [11:0] OFF_CLR  = 12'h008;
    localparam logic [11:0] OFF_EN   = 12'h00c;
    localparam logic [11:0] OFF_CNT  = 12'h010;
    localparam int unsigned BIT_FLAG = 7;
    localparam int unsigned TAP_LSB  = 4;
    localparam int unsigned BIT_ACK  = 3;
    localparam int unsigned BIT_IE   = 2;
    localparam int unsigned BIT_RUN  = 1;
    localparam int unsigned BIT_IRQ  = 0;
    localparam int unsigned TAP_W    = 3;
    localparam int unsigned PRE_W    = 7;
    localparam int unsigned CHAIN_W  = 15;
    localparam int unsigned CNT_W    = PRE_W + CHAIN_W;
    localparam logic [TAP_W-1:0]   TAP_RST  = 3'h0;
    localparam logic               IE_RST   = 1'b0;
    localparam logic               RUN_RST  = 1'b0;
    localparam logic               FLAG_RST = 1'b0;
    localparam logic [PRE_W-1:0]   PRE_LAST = 7'h7f;
    // Chain bit below each tap, code 0 in the low nibble
    localparam logic [31:0]        TAP_BITS = 32'h23456ace;
    localparam logic [31:0]        RDATA_RST = 32'h00000000;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_ACCESS = 2'b10
    } ptb_apb_e;
endpackage

// [shared/ptb_div_if.sv]
`timescale 1ns/1ns
interface ptb_div_if;
    logic                       tick;
    logic                       run;
    logic                       bank;
    logic [ptb_pkg::TAP_W-1:0]  tap;
    logic                       rollover;
    logic [ptb_pkg::CNT_W-1:0]  count;
    modport src (output tick);
    modport div (input tick, run, bank, tap, output rollover, count);
    modport ctl (output run, bank, tap, input rollover, count);
endinterface

// [logic/ptb_tick_sel.sv]
`timescale 1ns/1ns
module ptb_tick_sel (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Source clocks, sampled as levels
    input  wire logic external_clock,
    input  wire logic internal_clock,
    input  wire logic external_clock_on,
    input  wire logic freeze,
    // Divider side
    ptb_div_if.src    dv
);
    logic ext_q;
    logic ext_d;
    logic int_q;
    logic int_d;
    logic tick_q;
    logic tick_d;

    // Sources must stay at or below half of pclk, one tick per rising edge
    always_comb
    begin
        ext_d  = external_clock;
        int_d  = internal_clock;
        tick_d = 1'b0;
        if (freeze)
            tick_d = 1'b0;
        // RULE_06: external wins when on
        else if (external_clock_on)
            tick_d = external_clock & ~ext_q;
        else
            tick_d = internal_clock & ~int_q;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_q  <= 1'b0;
            int_q  <= 1'b0;
            tick_q <= 1'b0;
        end
        else
        begin
            ext_q  <= ext_d;
            int_q  <= int_d;
            tick_q <= tick_d;
        end
    end

    assign dv.tick = tick_q;
endmodule

// [logic/ptb_divider.sv]
`timescale 1ns/1ns
module ptb_divider (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control side
    ptb_div_if.div    dv
);
    logic [ptb_pkg::PRE_W-1:0]   pre_q;
    logic [ptb_pkg::PRE_W-1:0]   pre_d;
    logic [ptb_pkg::CHAIN_W-1:0] chain_q;
    logic [ptb_pkg::CHAIN_W-1:0] chain_d;
    logic                        step;
    logic                        roll_q;
    logic                        roll_d;
    logic [3:0]                  tap_bit;

    always_comb
    begin
        // RULE_07: same chain taps in both banks
        // RULE_08: bank one only adds the prescaler
        tap_bit = ptb_pkg::TAP_BITS[{dv.tap, 2'b00} +: 4];
        // RULE_14: divide-by-128 ahead of 15 stages in bank one only
        step    = dv.bank ? (dv.tick & (pre_q == ptb_pkg::PRE_LAST)) : dv.tick;
        pre_d   = pre_q + ptb_pkg::PRE_W'(dv.tick);
        chain_d = chain_q + ptb_pkg::CHAIN_W'(step);
        // RULE_05: rise of bit below tap, half then full period
        // RULE_02: flag event at the selected tap
        roll_d  = step & ~chain_q[tap_bit] & chain_d[tap_bit];
        // RULE_01: held at zero while stopped
        if (!dv.run)
        begin
            pre_d   = '0;
            chain_d = '0;
            roll_d  = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_q   <= '0;
            chain_q <= '0;
            roll_q  <= 1'b0;
        end
        else
        begin
            pre_q   <= pre_d;
            chain_q <= chain_d;
            roll_q  <= roll_d;
        end
    end

    assign dv.rollover = roll_q;
    assign dv.count    = {chain_q, pre_q};
endmodule

// [logic/ptb_timebase.sv]
`timescale 1ns/1ns
module ptb_timebase (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Clock generator
    input  wire logic        external_clock,
    input  wire logic        internal_clock,
    input  wire logic        external_clock_on,
    input  wire logic        tap_bank_select,
    input  wire logic        osc_keep_in_stop,
    // Power modes
    input  wire logic        wait_mode,
    input  wire logic        stop_mode,
    // Interrupt
    output logic             irq
);
    ptb_div_if dv ();

    ptb_pkg::ptb_apb_e         st_q;
    ptb_pkg::ptb_apb_e         st_d;
    logic [31:0]               rdata_q;
    logic [31:0]               rdata_d;
    logic                      err_q;
    logic                      err_d;
    logic [ptb_pkg::TAP_W-1:0] tap_q;
    logic [ptb_pkg::TAP_W-1:0] tap_d;
    logic                      ie_q;
    logic                      ie_d;
    logic                      run_q;
    logic                      run_d;
    logic                      flag_q;
    logic                      flag_d;
    logic                      irq_q;
    logic                      irq_d;
    logic                      freeze;
    logic                      blocked;
    logic                      setup;
    logic                      wr_en;
    logic                      ack;
    logic [7:0]                ctrl_rd;

    // RULE_10: stop freezes unless oscillator kept alive
    assign freeze  = stop_mode & ~osc_keep_in_stop;
    // RULE_11: register closed in wait and stop, counting goes on in wait
    assign blocked = wait_mode | stop_mode;

    assign dv.run  = run_q;
    assign dv.tap  = tap_q;
    assign dv.bank = tap_bank_select;

    ptb_tick_sel u_tick (
        .pclk              (pclk),
        .presetn           (presetn),
        .external_clock    (external_clock),
        .internal_clock    (internal_clock),
        .external_clock_on (external_clock_on),
        .freeze            (freeze),
        .dv                (dv.src)
    );

    ptb_divider u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .dv      (dv.div)
    );

    // Control register image; acknowledge bit always reads zero
    always_comb
    begin
        ctrl_rd                                                  = 8'h00;
        ctrl_rd[ptb_pkg::BIT_FLAG]                               = flag_q;
        ctrl_rd[ptb_pkg::TAP_LSB +: ptb_pkg::TAP_W]              = tap_q;
        ctrl_rd[ptb_pkg::BIT_IE]                                 = ie_q;
        ctrl_rd[ptb_pkg::BIT_RUN]                                = run_q;
    end

    assign setup = psel & ~penable;

    // Bus phase, read data and error taken at setup
    always_comb
    begin
        st_d    = st_q;
        rdata_d = rdata_q;
        err_d   = err_q;
        case (st_q)
            ptb_pkg::ST_IDLE:
            begin
                if (setup)
                begin
                    st_d    = ptb_pkg::ST_ACCESS;
                    rdata_d = ptb_pkg::RDATA_RST;
                    err_d   = 1'b0;
                    if (blocked)
                        err_d = 1'b1;
                    else if (paddr == ptb_pkg::OFF_CTRL)
                        rdata_d = {24'h000000, ctrl_rd};
                    else if (paddr == ptb_pkg::OFF_STAT)
                        rdata_d[ptb_pkg::BIT_IRQ] = flag_q;
                    else if (paddr == ptb_pkg::OFF_CLR)
                        rdata_d = ptb_pkg::RDATA_RST;
                    else if (paddr == ptb_pkg::OFF_EN)
                        rdata_d[ptb_pkg::BIT_IRQ] = ie_q;
                    else if (paddr == ptb_pkg::OFF_CNT)
                        rdata_d[ptb_pkg::CNT_W-1:0] = dv.count;
                    else
                        err_d = 1'b1;
                    if (!pwrite)
                        err_d = err_d;
                    else
                        rdata_d = ptb_pkg::RDATA_RST;
                end
            end
            ptb_pkg::ST_ACCESS:
            begin
                st_d = ptb_pkg::ST_IDLE;
            end
            default:
            begin
                st_d = ptb_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q    <= ptb_pkg::ST_IDLE;
            rdata_q <= ptb_pkg::RDATA_RST;
            err_q   <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    // One wait-free access cycle after each setup
    assign pready  = (st_q == ptb_pkg::ST_ACCESS);
    assign prdata  = rdata_q;
    assign pslverr = pready & err_q;

    // Writes land only at the completing edge, low byte lane only
    assign wr_en = pready & psel & penable & pwrite & ~err_q & pstrb[0];

    // RULE_09: tap changes while running are software's fault
    // Not blocked here; the tap bit may jump and skip or add one event
    always_comb
    begin
        tap_d = tap_q;
        ie_d  = ie_q;
        run_d = run_q;
        ack   = 1'b0;
        if (wr_en)
        begin
            if (paddr == ptb_pkg::OFF_CTRL)
            begin
                tap_d = pwdata[ptb_pkg::TAP_LSB +: ptb_pkg::TAP_W];
                ie_d  = pwdata[ptb_pkg::BIT_IE];
                run_d = pwdata[ptb_pkg::BIT_RUN];
                // RULE_04: one clears, zero has no effect
                ack   = pwdata[ptb_pkg::BIT_ACK];
            end
            else if (paddr == ptb_pkg::OFF_CLR)
            begin
                ack = pwdata[ptb_pkg::BIT_IRQ];
            end
            else if (paddr == ptb_pkg::OFF_EN)
            begin
                ie_d = pwdata[ptb_pkg::BIT_IRQ];
            end
        end
    end

    // Flag and interrupt level
    always_comb
    begin
        flag_d = flag_q;
        // RULE_12: only acknowledge clears, run bit ignored
        if (ack)
            flag_d = 1'b0;
        // RULE_16: set beats clear
        // RULE_02: divider event sets flag
        if (dv.rollover)
            flag_d = 1'b1;
        // RULE_03: request when set and enabled
        // RULE_15: level while both hold
        irq_d = flag_d & ie_d;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // RULE_13: run and enable cleared
            tap_q  <= ptb_pkg::TAP_RST;
            ie_q   <= ptb_pkg::IE_RST;
            run_q  <= ptb_pkg::RUN_RST;
            flag_q <= ptb_pkg::FLAG_RST;
            irq_q  <= 1'b0;
        end
        else
        begin
            tap_q  <= tap_d;
            ie_q   <= ie_d;
            run_q  <= run_d;
            flag_q <= flag_d;
            irq_q  <= irq_d;
        end
    end

    assign irq = irq_q;
endmodule

// [testbench/ptb_timebase_checker.sv]
`timescale 1ns/1ns
module ptb_timebase_checker (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Modes and interrupt
    input wire logic        osc_keep_in_stop,
    input wire logic        wait_mode,
    input wire logic        stop_mode,
    input wire logic        irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_block; psel && !penable && (wait_mode || stop_mode) ##1
        (wait_mode || stop_mode) |-> pslverr && prdata == 32'h0; endproperty
    a_block: assert property (p_block) else $error("access in low power");
    property p_unmap; psel && !penable && paddr > ptb_pkg::OFF_CNT |=> pslverr; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped accepted");
    property p_ack; psel && !penable && !pwrite && paddr == ptb_pkg::OFF_CTRL
        |=> !prdata[ptb_pkg::BIT_ACK]; endproperty
    a_ack: assert property (p_ack) else $error("ack bit read as one");
    property p_fall; $fell(irq) |-> $past(psel && penable && pwrite); endproperty
    a_fall: assert property (p_fall) else $error("irq dropped by itself");
    property p_stop; (stop_mode && !osc_keep_in_stop) [*4] ##0 !irq |=> !irq; endproperty
    a_stop: assert property (p_stop) else $error("irq rose in stop");
    property p_rst; $rose(presetn) |-> !irq && !pready; endproperty
    a_rst: assert property (p_rst) else $error("busy after reset");
endmodule

bind ptb_timebase ptb_timebase_checker u_chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_keep_in_stop(osc_keep_in_stop), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .irq(irq)
);

// [testbench/tb.sv]
`timescale 1ns/1ns
module tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_clk = 1'b0;
    logic        int_clk = 1'b0;
    logic        ext_on = 1'b0;
    logic        bank = 1'b0;
    logic        keep = 1'b0;
    logic        wait_m = 1'b0;
    logic        stop_m = 1'b0;
    logic        irq;
    logic        irq_d;
    logic        done_s;
    logic [32:0] seen_s;
    logic [32:0] exp_q[$];
    int          err_total = 0, comparisons = 0, seed = 64536;
    int          since = 0, gap = 0, rises = 0, n;
    int          div0[8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
    int          div1[8] = '{4194304, 1048576, 262144, 16384, 8192, 4096, 2048, 1024};

    ptb_timebase uut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_clock(ext_clk), .internal_clock(int_clk),
        .external_clock_on(ext_on), .tap_bank_select(bank), .osc_keep_in_stop(keep),
        .wait_mode(wait_m), .stop_mode(stop_m), .irq(irq)
    );

    initial
    begin
        forever #50 pclk = ~pclk;
    end

    // Internal source at half of pclk, external source at a quarter of pclk
    always @(posedge pclk)
    begin
        int_clk <= ~int_clk;
        if (int_clk)
            ext_clk <= ~ext_clk;
    end

    // Sampled mid-cycle, clear of edge updates
    always @(negedge pclk)
    begin
        done_s = psel && penable && pready === 1'b1;
        seen_s = {pslverr, prdata};
        since = since + 1;
        if (irq === 1'b1 && irq_d !== 1'b1)
        begin
            gap = since;
            since = 0;
            rises = rises + 1;
        end
        irq_d = irq;
    end

    always @(posedge pclk)
        if (done_s === 1'b1)
            check(seen_s, exp_q.pop_front());

    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        comparisons = comparisons + 1;
        if (seen !== want)
        begin
            err_total = err_total + 1;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       input logic [32:0] want);
        exp_q.push_back(want);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (done_s !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b0, 32'h0, {1'b0, d});
    endtask

    // Upper bits random: they must be ignored
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d | ($random(seed) & 32'hffffff00), 33'h0);
    endtask

    function automatic logic [31:0] cw(input logic [2:0] c, input logic a, input logic r);
        return {24'h0, 1'b0, c, a, 1'b1, r, 1'b0};
    endfunction

    task automatic wait_rise(input int lim);
        int r;
        r = rises;
        for (int t = 0; t < lim && rises == r; t++)
            @(negedge pclk);
        // Back on the rising edge before any input moves
        @(posedge pclk);
    endtask

    task automatic period(input logic b, input logic [2:0] c);
        int dv;
        dv = b ? div1[c] : div0[c];
        wr(ptb_pkg::OFF_CTRL, 32'h0);
        wr(ptb_pkg::OFF_CTRL, cw(c, 1'b1, 1'b0));
        bank <= b;
        wr(ptb_pkg::OFF_CTRL, cw(c, 1'b0, 1'b1));
        since = 0;
        wait_rise(4 * dv);
        check(33'(gap >= dv - 2 && gap <= dv + 8), 33'h1);
        wr(ptb_pkg::OFF_CLR, 32'h1);
        wait_rise(4 * dv + 20);
        check(33'(gap), 33'(2 * dv));
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge pclk);
        err_total = err_total + 1;
        print_verdict();
    end

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 5; a++)
            rd(12'(a * 4), 32'h0);
        apb(12'h014, 1'b0, 32'h0, {1'b1, 32'h0});
        apb(12'h002, 1'b0, 32'h0, {1'b1, 32'h0});
        for (int i = 0; i < 7; i++)
            period(i > 4, 3'(i > 4 ? 12 - i : 7 - i));
        wr(ptb_pkg::OFF_CTRL, 32'h0);
        wr(ptb_pkg::OFF_CTRL, cw(3'h7, 1'b1, 1'b0));
        bank <= 1'b0;
        wr(ptb_pkg::OFF_CTRL, cw(3'h7, 1'b0, 1'b1));
        wait_rise(60);
        rd(ptb_pkg::OFF_CTRL, cw(3'h7, 1'b0, 1'b1) | 32'h80);
        wr(ptb_pkg::OFF_CTRL, cw(3'h7, 1'b0, 1'b0));
        rd(ptb_pkg::OFF_STAT, 32'h1);
        rd(ptb_pkg::OFF_CNT, 32'h0);
        wr(ptb_pkg::OFF_CTRL, 32'h70);
        rd(ptb_pkg::OFF_STAT, 32'h1);
        wr(ptb_pkg::OFF_EN, 32'h1);
        rd(ptb_pkg::OFF_CTRL, cw(3'h7, 1'b0, 1'b0) | 32'h80);
        wr(ptb_pkg::OFF_CTRL, cw(3'h7, 1'b1, 1'b0));
        rd(ptb_pkg::OFF_STAT, 32'h0);
        ext_on <= 1'b1;
        wr(ptb_pkg::OFF_CTRL, cw(3'h7, 1'b0, 1'b1));
        wait_rise(120);
        wr(ptb_pkg::OFF_CLR, 32'h1);
        wait_rise(120);
        check(33'(gap), 33'd32);
        ext_on <= 1'b0;
        wr(ptb_pkg::OFF_CLR, 32'h1);
        wait_rise(120);
        wr(ptb_pkg::OFF_CLR, 32'h1);
        stop_m <= 1'b1;
        n = rises;
        apb(ptb_pkg::OFF_STAT, 1'b0, 32'h0, {1'b1, 32'h0});
        repeat (100) @(posedge pclk);
        check(33'(rises), 33'(n));
        keep <= 1'b1;
        wait_rise(60);
        check(33'(rises), 33'(n + 1));
        stop_m <= 1'b0;
        keep <= 1'b0;
        wr(ptb_pkg::OFF_CLR, 32'h1);
        wait_m <= 1'b1;
        n = rises;
        apb(ptb_pkg::OFF_CLR, 1'b1, 32'h1, {1'b1, 32'h0});
        wait_rise(60);
        check(33'(rises), 33'(n + 1));
        wait_m <= 1'b0;
        print_verdict();
    end
endmodule
